// File: core/pmf_coef.v
// Purpose: coefficient store grouped for one multiply-add element
// Assumes: written by the loader, read combinationally by slot
// Notes:   four words, cleared at reset
`timescale 1ns/10ps
`include "pmf_consts.vh"

module pmf_coef (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      rst_n,
	// write side
	input  wire                      wr,
	input  wire [`PMF_SLOT_W-1:0]    wslot,
	input  wire [`PMF_CW-1:0]        wdata,
	// read side
	input  wire [`PMF_SLOT_W-1:0]    rslot,
	output wire [`PMF_CW-1:0]        rdata
);

	reg  [`PMF_CW-1:0] mem_ff [0:`PMF_DEPTH-1];
	integer            i;

	// coefficient words, rotating read by slot
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `PMF_DEPTH; i = i + 1) begin
				mem_ff[i] <= {`PMF_CW{1'b0}};
			end
		end else if (wr) begin
			mem_ff[wslot] <= wdata;
		end
	end

	assign rdata = mem_ff[rslot];

endmodule

// File: core/pmf_consts.vh
// Purpose: shared constants of the polyphase multirate fir
// Assumes: 16-bit samples and coefficients, 40-bit sums
// Notes:   definitions only
`ifndef PMF_CONSTS_VH
`define PMF_CONSTS_VH

// widths
`define PMF_DW        16
`define PMF_CW        16
`define PMF_PW        32
`define PMF_AW        40
`define PMF_EXT       8

// structure
`define PMF_NELEM     4
`define PMF_DEPTH     4
`define PMF_SLOT_W    2
`define PMF_ADDR_W    4
`define PMF_IP_TAPS   3

// decimator timing: one sample every PMF_SPACING clocks
`define PMF_SPACING   4
`define PMF_M         16
`define PMF_LAG       17

// sequence limits
`define PMF_SLOT_TOP  2'h3
`define PMF_SLOT_BOT  2'h0
`define PMF_IP_LAST   2'h2
`define PMF_PH_LAST   2'h3
`define PMF_PH_FIRST  2'h0

// alu input select codes
`define PMF_SEL_LOAD  2'h0
`define PMF_SEL_ACC   2'h1
`define PMF_SEL_CASC  2'h2
`define PMF_SEL_HOLD  2'h3

// modes
`define PMF_MODE_IP   1'h0
`define PMF_MODE_DEC  1'h1

`endif

// File: core/pmf_mac.v
// Purpose: signed multiply-add element with accumulator and cascade
// Assumes: sel is the alu input selection of the current cycle
// Notes:   product sign-extended into the 40-bit sum path
`timescale 1ns/10ps
`include "pmf_consts.vh"

module pmf_mac (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      rst_n,
	// control
	input  wire                      en,
	input  wire [1:0]                alu_input_select,
	// operands
	input  wire signed [`PMF_CW-1:0] coef,
	input  wire signed [`PMF_DW-1:0] smp,
	input  wire signed [`PMF_AW-1:0] cascade_sum_in,
	// results
	output wire signed [`PMF_AW-1:0] acc,
	output wire signed [`PMF_AW-1:0] cascade_sum_out,
	output wire                      cas_vld
);

	reg  signed [`PMF_AW-1:0] acc_ff;
	reg  signed [`PMF_AW-1:0] casc_ff;
	reg                       cas_vld_ff;
	wire signed [`PMF_PW-1:0] prod;
	wire signed [`PMF_AW-1:0] prod_x;

	// two's complement multiplier feeding the adder
	assign prod   = coef * smp; // [R12]
	assign prod_x = {{`PMF_EXT{prod[`PMF_PW-1]}}, prod};

	// load, accumulate or add cascade, per alu input select
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff     <= {`PMF_AW{1'b0}};
			casc_ff    <= {`PMF_AW{1'b0}};
			cas_vld_ff <= 1'b0;
		end else begin
			cas_vld_ff <= 1'b0;
			if (en) begin
				case (alu_input_select)
				`PMF_SEL_LOAD: begin
					acc_ff <= prod_x; // [R12]
				end
				`PMF_SEL_ACC: begin
					acc_ff <= acc_ff + prod_x; // [R12]
				end
				`PMF_SEL_CASC: begin
					casc_ff    <= acc_ff + prod_x + cascade_sum_in; // [R12]
					cas_vld_ff <= 1'b1;
				end
				default: begin
					acc_ff <= acc_ff;
				end
				endcase
			end
		end
	end

	assign acc             = acc_ff;
	assign cascade_sum_out = casc_ff;
	assign cas_vld         = cas_vld_ff;

endmodule

// File: core/pmf_top.v
// Purpose: polyphase fir, 12-tap 1:4 interpolator or 16-tap 4:1 decimator
// Assumes: one sample per 4 clocks at most; coefficients loaded idle
// Notes:   four multiply-add elements shared by both modes
`timescale 1ns/10ps
`include "pmf_consts.vh"

// What this block does
// R1: interpolation gives four outputs per input
// R2: phase k uses h_k, h_k+4, h_k+8
// R3: phases equal elements; taps set store depth
// R4: coefficients grouped per element, rotating read
// R5: decimation: 16 taps over four elements
// R6: one decimated output per four inputs
// R7: decimated output is full 16-tap convolution
// R8: each element's data lags previous by M+1
// R9: latency: element stages, phases-1, plus two
// R10: decimated result taken from fourth element
// R11: alu input select switched per cycle
// R12: elements: signed multiply, add, cascade, accumulate
// R13: interpolated phases leave in order 0..3
// R14: source spaces samples at least four clocks
module pmf_top (
	// clock and reset
	input  wire                      ref_clk,
	input  wire                      rst_n,
	// mode: 0 interpolate, 1 decimate
	input  wire                      mode,
	// coefficient load
	input  wire                      coef_wr,
	input  wire [`PMF_ADDR_W-1:0]    coef_addr,
	input  wire [`PMF_CW-1:0]        coef_data,
	// sample input
	input  wire                      in_valid,
	input  wire [`PMF_DW-1:0]        in_data,
	// result output
	output reg                       out_valid_ff,
	output reg  [`PMF_AW-1:0]        out_data_ff,
	output reg  [`PMF_SLOT_W-1:0]    out_phase_ff
);

	// tap index to {element, slot}: element-major in decimation
	function [`PMF_ADDR_W-1:0] map_coef;
		input                   dec;
		input [`PMF_ADDR_W-1:0] addr;
		begin
			if (dec) begin
				map_coef = addr;
			end else begin
				map_coef = {addr[1:0], addr[3:2]};
			end
		end
	endfunction

	// input stage and mode tracking
	reg                      mode_ff;
	reg                      in_vld_ff;
	reg  [`PMF_DW-1:0]       in_ff;
	wire                     flush;
	wire                     decim;

	// interpolation sequencing
	reg  [`PMF_DW-1:0]       hist_ff [0:`PMF_IP_TAPS-1];
	reg                      ip_busy_ff;
	reg  [1:0]               ip_cnt_ff;
	reg                      ip_done_ff;
	reg  [`PMF_AW-1:0]       bank_ff [0:`PMF_NELEM-1];
	reg                      ser_busy_ff;
	reg  [1:0]               ser_ph_ff;

	// element interconnect, one slice per element
	wire [`PMF_NELEM-1:0]            tap_vld;
	wire [`PMF_NELEM*`PMF_DW-1:0]    tap_dat;
	wire [`PMF_NELEM*`PMF_AW-1:0]    accs;
	wire [`PMF_NELEM*`PMF_AW-1:0]    csum;
	wire [(`PMF_NELEM+1)*`PMF_AW-1:0] csum_ext;
	wire [`PMF_NELEM-1:0]            cvld;
	// per element: add the cascade sum in on this clock
	wire [`PMF_NELEM-1:0]            casc_go;
	wire [`PMF_ADDR_W-1:0]           wmap;
	integer                          i;

	assign decim    = (mode_ff == `PMF_MODE_DEC);
	assign flush    = (mode != mode_ff);
	assign wmap     = map_coef(mode, coef_addr);
	assign csum_ext = {csum, {`PMF_AW{1'b0}}};

	// stage ahead of the filter, and mode register.
	// a mode change flushes counters and delay-line valids for a clock;
	// coefficients stay, but their mapping differs, so reload them
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff   <= `PMF_MODE_IP;
			in_vld_ff <= 1'b0;
			in_ff     <= {`PMF_DW{1'b0}};
		end else begin
			mode_ff   <= mode;
			in_vld_ff <= in_valid & ~flush; // [R9]
			in_ff     <= in_data;
		end
	end

	// decimator feed enters the first element directly
	assign tap_vld[0]            = in_vld_ff & decim;
	assign tap_dat[`PMF_DW-1:0]  = in_ff;

	// interpolation: keep newest three samples, run three mac cycles.
	// a sample taken on one clock shifts into the history on the next,
	// the elements load, add and add on the three clocks after that,
	// the bank catches the sums and the four phases leave one a clock,
	// so the first phase is registered six clocks after the sample.
	// a sample sooner than four clocks after the last drops the burst of the last
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `PMF_IP_TAPS; i = i + 1) begin
				hist_ff[i] <= {`PMF_DW{1'b0}};
			end
			ip_busy_ff <= 1'b0;
			ip_cnt_ff  <= `PMF_PH_FIRST;
			ip_done_ff <= 1'b0;
		end else begin
			ip_done_ff <= 1'b0;
			if (flush) begin
				ip_busy_ff <= 1'b0;
				ip_cnt_ff  <= `PMF_PH_FIRST;
			end else if (in_vld_ff && !decim) begin
				hist_ff[2] <= hist_ff[1]; // [R2]
				hist_ff[1] <= hist_ff[0];
				hist_ff[0] <= in_ff;
				ip_busy_ff <= 1'b1;
				ip_cnt_ff  <= `PMF_PH_FIRST;
			end else if (ip_busy_ff) begin
				if (ip_cnt_ff == `PMF_IP_LAST) begin
					ip_busy_ff <= 1'b0;
					ip_cnt_ff  <= `PMF_PH_FIRST;
					ip_done_ff <= 1'b1;
				end else begin
					ip_cnt_ff <= ip_cnt_ff + 2'h1;
				end
			end
		end
	end

	// catch the four phase sums, then emit one per clock
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `PMF_NELEM; i = i + 1) begin
				bank_ff[i] <= {`PMF_AW{1'b0}};
			end
			ser_busy_ff <= 1'b0;
			ser_ph_ff   <= `PMF_PH_FIRST;
		end else begin
			if (flush) begin
				ser_busy_ff <= 1'b0;
				ser_ph_ff   <= `PMF_PH_FIRST;
			end else if (ip_done_ff) begin
				for (i = 0; i < `PMF_NELEM; i = i + 1) begin
					bank_ff[i] <= accs[i*`PMF_AW +: `PMF_AW]; // [R1]
				end
				ser_busy_ff <= 1'b1;
				ser_ph_ff   <= `PMF_PH_FIRST;
			end else if (ser_busy_ff) begin
				ser_ph_ff <= ser_ph_ff + 2'h1; // [R13]
				if (ser_ph_ff == `PMF_PH_LAST) begin
					ser_busy_ff <= 1'b0;
				end
			end
		end
	end

	// output register, stage after the filter.
	// a decimated result is registered five clocks after its newest sample
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_ff <= 1'b0;
			out_data_ff  <= {`PMF_AW{1'b0}};
			out_phase_ff <= `PMF_PH_FIRST;
		end else begin
			out_valid_ff <= 1'b0;
			if (!decim && ser_busy_ff && !flush) begin
				out_valid_ff <= 1'b1; // [R1]
				out_data_ff  <= bank_ff[ser_ph_ff]; // [R13]
				out_phase_ff <= ser_ph_ff;
			end else if (decim && cvld[`PMF_NELEM-1] && !flush) begin
				out_valid_ff <= 1'b1; // [R6] [R9]
				out_data_ff  <= csum[(`PMF_NELEM-1)*`PMF_AW +: `PMF_AW]; // [R10]
				out_phase_ff <= `PMF_PH_FIRST;
			end
		end
	end

	// data delay lines between elements in decimation: four samples of
	// four clocks plus one, so an element meets the sum of the element
	// before it one clock after that sum is registered; any other sample
	// spacing puts the data out of line with the sums
	genvar e;
	generate
		for (e = 1; e < `PMF_NELEM; e = e + 1) begin : g_dly
			reg  [`PMF_DW:0] dly_ff [0:`PMF_LAG-1];
			integer          k;

			// shift {valid, data} by M+1 clocks
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					for (k = 0; k < `PMF_LAG; k = k + 1) begin
						dly_ff[k] <= {(`PMF_DW+1){1'b0}};
					end
				end else begin
					dly_ff[0] <= {tap_vld[e-1] & ~flush,
						tap_dat[(e-1)*`PMF_DW +: `PMF_DW]}; // [R8]
					for (k = 1; k < `PMF_LAG; k = k + 1) begin
						dly_ff[k] <= {dly_ff[k-1][`PMF_DW] & ~flush,
							dly_ff[k-1][`PMF_DW-1:0]};
					end
				end
			end

			assign tap_vld[e]                    = dly_ff[`PMF_LAG-1][`PMF_DW];
			assign tap_dat[e*`PMF_DW +: `PMF_DW] = dly_ff[`PMF_LAG-1][`PMF_DW-1:0];
		end
	endgenerate

	// four elements with their coefficient groups
	generate
		for (e = 0; e < `PMF_NELEM; e = e + 1) begin : g_elem
			reg  [1:0]           dslot_ff;
			wire [1:0]           rslot;
			wire [1:0]           sel;
			wire                 en;
			wire [`PMF_CW-1:0]   cf;
			wire [`PMF_DW-1:0]   smp;
			wire [`PMF_DW-1:0]   dsmp;

			// decimation slot: h(4e+3) first, down to h(4e)
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					dslot_ff <= `PMF_SLOT_TOP;
				end else if (flush) begin
					dslot_ff <= `PMF_SLOT_TOP;
				end else if (decim && tap_vld[e]) begin
					dslot_ff <= dslot_ff - 2'h1; // [R4] [R7]
				end
			end

			// cascade strobe: element 0 closes a group, later ones follow
			// the previous element by one clock. with samples exactly four
			// clocks apart the delayed data of element e reaches its last
			// slot on that same clock, so strobe and data line up; before
			// the delay lines fill the strobe still passes the sum on with
			// zero history, and once the input stops the tail of the delay
			// lines no longer makes a result
			if (e == 0) begin : g_head
				assign casc_go[e] = tap_vld[e] & (dslot_ff == `PMF_SLOT_BOT); // [R6]
			end else begin : g_link
				assign casc_go[e] = cvld[e-1]; // [R10]
			end

			assign rslot = decim ? dslot_ff : ip_cnt_ff; // [R4]
			assign en    = decim ? (tap_vld[e] | casc_go[e]) : ip_busy_ff;
			// no sample on this clock: keep the product out of the sum
			assign dsmp  = tap_vld[e] ? tap_dat[e*`PMF_DW +: `PMF_DW] : {`PMF_DW{1'b0}};
			assign smp   = decim ? dsmp : hist_ff[ip_cnt_ff]; // [R2]
			// per-cycle alu selection: load, accumulate or add cascade
			assign sel   = decim ?
				(casc_go[e] ? `PMF_SEL_CASC :
				 (dslot_ff == `PMF_SLOT_TOP) ? `PMF_SEL_LOAD : `PMF_SEL_ACC) :
				((ip_cnt_ff == `PMF_PH_FIRST) ? `PMF_SEL_LOAD : `PMF_SEL_ACC); // [R11]

			// one store per element, depth from tap count
			pmf_coef u_coef (
				.ref_clk (ref_clk),
				.rst_n   (rst_n),
				.wr      (coef_wr && (wmap[3:2] == e)), // [R3] [R4]
				.wslot   (wmap[1:0]),
				.wdata   (coef_data),
				.rslot   (rslot),
				.rdata   (cf)
			);

			// element e: interp phase e, or decim taps 4e..4e+3
			pmf_mac u_mac (
				.ref_clk          (ref_clk),
				.rst_n            (rst_n),
				.en               (en),
				.alu_input_select (sel),
				.coef             (cf),
				.smp              (smp),
				.cascade_sum_in   (csum_ext[e*`PMF_AW +: `PMF_AW]), // [R5] [R7]
				.acc              (accs[e*`PMF_AW +: `PMF_AW]),
				.cascade_sum_out  (csum[e*`PMF_AW +: `PMF_AW]),
				.cas_vld          (cvld[e])
			);
		end
	endgenerate

endmodule

// File: tb/pmf_src.sv
// Purpose: upstream sample source for the polyphase fir
// Assumes: go pulses with a sample count
// Notes:   sample j is 7fff - j*1111; idle data toggles every cycle
`timescale 1ns/10ps
module pmf_src (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// control
	input  wire        go,
	input  wire [7:0]  count,
	// stream
	output wire        in_valid,
	output wire [15:0] in_data
);
	reg [7:0]  left_ff;
	reg [7:0]  idx_ff;
	reg [1:0]  gap_ff;
	reg        vld_ff;
	reg [15:0] dat_ff;
	assign in_valid = vld_ff;
	assign in_data  = dat_ff;
	// one sample every four clocks
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_ff <= 8'h0;
			idx_ff  <= 8'h0;
			gap_ff  <= 2'h0;
			vld_ff  <= 1'b0;
			dat_ff  <= 16'h0;
		end else begin
			gap_ff <= gap_ff + 2'h1;
			vld_ff <= 1'b0;
			dat_ff <= ~dat_ff; // idle data alternates between the inverse of the last sample and the sample
			if (go) begin
				left_ff <= count;
				gap_ff  <= 2'h0;
			end else if (left_ff != 8'h0 && gap_ff == 2'h3) begin
				vld_ff  <= 1'b1;
				dat_ff  <= 16'h7fff - {8'h0, idx_ff} * 16'h1111;
				idx_ff  <= idx_ff + 8'h1;
				left_ff <= left_ff - 8'h1;
			end
		end
	end
endmodule

// File: tb/pmf_top_properties.sv
// Purpose: port assertions for the polyphase fir
// Assumes: samples four clocks apart, mode steady while results are due
// Notes:   bound from the bench top
`timescale 1ns/10ps
module pmf_props (
	// clock and reset
	input wire        ref_clk,
	input wire        rst_n,
	// inputs
	input wire        mode,
	input wire        in_valid,
	// results
	input wire        out_valid_ff,
	input wire [39:0] out_data_ff,
	input wire [1:0]  out_phase_ff
);
	reg  [1:0] cnt_ff;
	reg        mode_q_ff;
	wire       take4;
	// fourth sample of a decimation group, no mode change
	assign take4 = in_valid && mode && mode_q_ff && cnt_ff == 2'h3;
	// count taken decimation samples
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff    <= 2'h0;
			mode_q_ff <= 1'b0;
		end else begin
			mode_q_ff <= mode;
			if (mode != mode_q_ff)
				cnt_ff <= 2'h0;
			else if (in_valid && mode)
				cnt_ff <= cnt_ff + 2'h1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_IP_FOUR: assert property (
		in_valid && !mode && !mode_q_ff |-> ##7 out_valid_ff && out_phase_ff == 2'h0
		##1 out_valid_ff && out_phase_ff == 2'h1 ##1 out_valid_ff && out_phase_ff == 2'h2
		##1 out_valid_ff && out_phase_ff == 2'h3) else $error("interp burst wrong");
	AST_IP_ORDER: assert property (
		out_valid_ff && !mode && out_phase_ff != 2'h3 |=>
		out_valid_ff && out_phase_ff == $past(out_phase_ff) + 2'h1) else $error("phase order");
	AST_IP_CAUSE: assert property (
		out_valid_ff && !mode && out_phase_ff == 2'h0 |-> $past(in_valid, 7))
		else $error("interp result without sample");
	AST_DEC_PH0: assert property (out_valid_ff && mode |-> out_phase_ff == 2'h0)
		else $error("decim phase not zero");
	AST_DEC_LAT: assert property (take4 |-> ##6 out_valid_ff)
		else $error("decim latency");
	AST_DEC_CAUSE: assert property (out_valid_ff && mode |-> $past(take4, 6))
		else $error("decim result without group");
	AST_DEC_GAP: assert property (out_valid_ff && mode |=> !out_valid_ff [*8])
		else $error("decim results too close");
	AST_HOLD: assert property (!out_valid_ff |-> $stable(out_data_ff))
		else $error("result moved without valid");
endmodule

// File: tb/pmf_top_tb.sv
// Purpose: self-checking bench for the polyphase fir
// Assumes: reset clears history and coefficients
// Notes:   interpolation then decimation, each after a reset
`timescale 1ns/10ps
module pmf_top_tb;
	reg         ref_clk;
	reg         rst_n;
	reg         mode;
	reg         coef_wr;
	reg  [3:0]  coef_addr;
	reg  [15:0] coef_data;
	reg         go;
	reg  [7:0]  count;
	wire        in_valid;
	wire [15:0] in_data;
	wire        out_valid_ff;
	wire [39:0] out_data_ff;
	wire [1:0]  out_phase_ff;
	integer     n_errors;
	integer     n_tests;
	integer     cyc;
	integer     it[$];
	integer     ot[$];
	reg  [39:0] oq[$];
	reg  [1:0]  pq[$];
	pmf_top u_pmf_top (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode), .coef_wr(coef_wr),
		.coef_addr(coef_addr), .coef_data(coef_data), .in_valid(in_valid),
		.in_data(in_data), .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff),
		.out_phase_ff(out_phase_ff));
	pmf_src u_pmf_src (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .count(count),
		.in_valid(in_valid), .in_data(in_data));
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	function [15:0] xs(input integer j);
		xs = (j < 0) ? 16'h0 : 16'h7fff - j * 16'h1111;
	endfunction
	function [15:0] h(input integer i);
		h = 16'h0123 * i - 16'h0500;
	endfunction
	function signed [39:0] yi(input integer n, input integer k);
		yi = $signed(h(k)) * $signed(xs(n)) + $signed(h(k + 4)) * $signed(xs(n - 1))
			+ $signed(h(k + 8)) * $signed(xs(n - 2));
	endfunction
	function signed [39:0] yd(input integer m);
		integer i;
		begin
			yd = 40'h0;
			for (i = 0; i < 16; i = i + 1)
				yd = yd + $signed(h(i)) * $signed(xs(4 * m + 3 - i));
		end
	endfunction
	// monitor and timeout
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (in_valid)
			it.push_back(cyc);
		if (out_valid_ff) begin
			oq.push_back(out_data_ff);
			pq.push_back(out_phase_ff);
			ot.push_back(cyc);
		end
		if (cyc > 3000) begin
			n_errors = n_errors + 1;
			stop_test;
		end
	end
	task check(input string what, input [39:0] e, input [39:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("BAD %s exp %h got %h", what, e, g);
			end
		end
	endtask
	task do_reset(input m);
		begin
			rst_n <= 1'b0;
			mode  <= m;
			repeat (16) @(posedge ref_clk);
			rst_n <= 1'b1;
			repeat (2) @(posedge ref_clk);
			it.delete();
			ot.delete();
			oq.delete();
			pq.delete();
		end
	endtask
	task load(input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				coef_wr   <= 1'b1;
				coef_addr <= i[3:0];
				coef_data <= h(i);
				@(posedge ref_clk);
			end
			coef_wr <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task run(input [7:0] n, input integer k);
		integer i;
		begin
			count <= n;
			go    <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			for (i = 0; i < 600 && oq.size() < k; i = i + 1)
				@(posedge ref_clk);
			repeat (20) @(posedge ref_clk);
		end
	endtask
	task t_interp;
		integer n;
		integer k;
		begin
			do_reset(1'b0);
			load(12);
			run(8'd6, 24);
			check("count", 40'd24, oq.size());
			for (n = 0; n < 6; n = n + 1)
				for (k = 0; k < 4; k = k + 1) begin
					check("data", yi(n, k), oq[n * 4 + k]);
					check("phase", k, pq[n * 4 + k]);
					check("lag", 7 + k, ot[n * 4 + k] - it[n]);
				end
		end
	endtask
	task t_decim;
		integer m;
		begin
			do_reset(1'b1);
			load(16);
			run(8'd16, 4);
			check("count", 40'd4, oq.size());
			for (m = 0; m < 4; m = m + 1) begin
				check("data", yd(m), oq[m]);
				check("lag", 40'd6, ot[m] - it[4 * m + 3]);
			end
		end
	endtask
	task stop_test;
		begin
			$display("tests %0d errors %0d", n_tests, n_errors);
			if (n_errors == 0 && n_tests > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		ref_clk   = 1'b0;
		rst_n     = 1'b0;
		mode      = 1'b0;
		coef_wr   = 1'b0;
		coef_addr = 4'h0;
		coef_data = 16'h0;
		go        = 1'b0;
		count     = 8'h0;
		n_errors  = 0;
		n_tests   = 0;
		cyc       = 0;
		t_interp;
		t_decim;
		stop_test;
	end
endmodule
bind pmf_top pmf_props u_pmf_props (.ref_clk(ref_clk), .rst_n(rst_n), .mode(mode),
	.in_valid(in_valid), .out_valid_ff(out_valid_ff), .out_data_ff(out_data_ff),
	.out_phase_ff(out_phase_ff));
